//--- hw/dsmsel_top.sv
// Modulator source and carrier selection with Wishbone registers
// Assumes rst_i is a power-on reset and peripheral signals are asynchronous
// Operation
// - Source disable bit blocks the chosen source peripheral from its pin.
// - Source code 0 picks manual bit, code 1 picks modulation pin.
// - Source codes 2 and 3 pick serial outputs one and two.
// - Source codes 4 to 7 pick UART transmit one to four.
// - Source codes 8 to 14 pick compare outputs; code 15 selects nothing.
// - Source disable bit is reset only by power-on reset.
// - Source select bits are untouched by power-on reset.
// - High carrier disable bit blocks chosen carrier peripheral from its pin.
// - High carrier invert bit inverts high carrier before mixing.
// - High sync holds switch to low until high carrier falls.
// - Carrier codes 0 to 3: ground, pin one, pin two, reference clock.
// - Carrier codes 4 to 10 pick compare outputs; above reserved.
// - Low carrier disable blocks its peripheral pin and resets to zero.
// - Low carrier invert bit inverts low carrier before mixing.
// - Low sync holds switch to high until low carrier falls.
// - Low carrier select uses the same code map as high.
// - Unimplemented bits read zero and ignore writes.
// - Without sync, carrier switch is immediate and may glitch.
// - Output is high carrier while modulating signal is high, else low carrier.
// - Disabled module produces no modulated output.
// - Output invert bit inverts the final output while the module is enabled.
// - Software manual bit is the modulating signal in manual mode.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps

module dsmsel_sync3 (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic d_i, // Asynchronous level
  output logic q_o // Filtered level
);
  logic [2:0] stage;
  logic next_q;
  assign next_q = (stage[1] == stage[2]) ? stage[2] : q_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage <= 3'h0;
      q_o <= 1'b0;
    end else begin
      stage <= {stage[1:0], d_i};
      q_o <= next_q;
    end
  end
endmodule

module dsmsel_top (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_i, // Power-on reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [dsmsel_pkg::adr_width-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire dsmsel_pkg::dsmsel_inputs_type sig_i, // Peripheral and pin inputs
  output dsmsel_pkg::dsmsel_pin_enable_type pin_en_o, // Peripheral pin drive enables
  output logic modulated_output_pin_o // Modulated output
);
  localparam int unsigned n_in = $bits(dsmsel_pkg::dsmsel_inputs_type);

  logic [15:0] ctrl_reg;
  logic [7:0] src_reg;
  logic [15:0] car_reg;
  logic src_disable;
  logic [3:0] src_code;
  logic [n_in-1:0] raw_bits;
  logic [n_in-1:0] sync_bits;
  dsmsel_pkg::dsmsel_inputs_type s;
  dsmsel_pkg::dsmsel_path_type path;
  logic hi_prev;
  logic lo_prev;
  logic out_q;
  logic ack_q;
  logic [31:0] rdat_q;
  dsmsel_pkg::dsmsel_pin_enable_type en_q;

  // Input synchronisers
  assign raw_bits = sig_i;
  genvar gi;
  generate
    for (gi = 0; gi < n_in; gi++) begin : g_sync
      dsmsel_sync3 u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(raw_bits[gi]),
        .q_o(sync_bits[gi])
      );
    end
  endgenerate
  assign s = sync_bits;

  // Register fields
  wire enable = ctrl_reg[dsmsel_pkg::ctl_enable_bit];
  wire out_inv = ctrl_reg[dsmsel_pkg::ctl_invert_bit];
  wire manual_modulation_value = ctrl_reg[dsmsel_pkg::ctl_manual_bit];
  wire hi_dis = car_reg[dsmsel_pkg::hi_disable_bit];
  wire hi_inv = car_reg[dsmsel_pkg::hi_invert_bit];
  wire hi_sync = car_reg[dsmsel_pkg::hi_sync_bit];
  wire [3:0] hi_sel = car_reg[dsmsel_pkg::hi_sel_lsb +: 4];
  wire lo_dis = car_reg[dsmsel_pkg::lo_disable_bit];
  wire lo_inv = car_reg[dsmsel_pkg::lo_invert_bit];
  wire lo_sync = car_reg[dsmsel_pkg::lo_sync_bit];
  wire [3:0] lo_sel = car_reg[dsmsel_pkg::lo_sel_lsb +: 4];

  // Source selection
  wire [3:0] spi_idx = src_code - dsmsel_pkg::src_spi_first;
  wire [3:0] uart_idx = src_code - dsmsel_pkg::src_uart_first;
  wire [3:0] cmp_idx = src_code - dsmsel_pkg::src_cmp_first;
  wire is_pin = src_code == dsmsel_pkg::src_pin;
  wire is_spi = (src_code >= dsmsel_pkg::src_spi_first) &&
      (src_code < dsmsel_pkg::src_uart_first);
  wire is_uart = (src_code >= dsmsel_pkg::src_uart_first) &&
      (src_code < dsmsel_pkg::src_cmp_first);
  wire is_cmp = (src_code >= dsmsel_pkg::src_cmp_first) &&
      (src_code != dsmsel_pkg::src_none);
  wire modulator =
      (src_code == dsmsel_pkg::src_manual) ? manual_modulation_value :
      is_pin ? s.mod_pin :
      is_spi ? s.spi_sdo[spi_idx[0]] :
      is_uart ? s.uart_tx[uart_idx[1:0]] :
      is_cmp ? s.cmp_out[cmp_idx[2:0]] :
      1'b0;

  // Carrier selection, one map for both carriers
  function automatic logic car_pick(input logic [3:0] code,
                                    input dsmsel_pkg::dsmsel_inputs_type v);
    logic [3:0] k;
    k = code - dsmsel_pkg::car_cmp_first;
    case (code)
      dsmsel_pkg::car_ground: car_pick = 1'b0;
      dsmsel_pkg::car_pin_one: car_pick = v.car_pin_one;
      dsmsel_pkg::car_pin_two: car_pick = v.car_pin_two;
      dsmsel_pkg::car_refclk: car_pick = v.refclk;
      default: car_pick = (code >= dsmsel_pkg::car_cmp_first &&
          code <= dsmsel_pkg::car_cmp_last) ? v.cmp_out[k[2:0]] : 1'b0;
    endcase
  endfunction

  wire hi_raw = car_pick(hi_sel, s);
  wire lo_raw = car_pick(lo_sel, s);
  wire hi_car = hi_raw ^ hi_inv;
  wire lo_car = lo_raw ^ lo_inv;
  wire hi_fall = hi_prev & ~hi_car;
  wire lo_fall = lo_prev & ~lo_car;

  // Path switching with optional edge hold
  dsmsel_pkg::dsmsel_path_type next_path;
  always_comb begin
    next_path = path;
    if (modulator && path == dsmsel_pkg::dsmsel_use_low) begin
      if (!lo_sync || lo_fall) begin
        next_path = dsmsel_pkg::dsmsel_use_high;
      end
    end else if (!modulator && path == dsmsel_pkg::dsmsel_use_high) begin
      if (!hi_sync || hi_fall) begin
        next_path = dsmsel_pkg::dsmsel_use_low;
      end
    end
  end

  wire mixed = (hi_car & (next_path == dsmsel_pkg::dsmsel_use_high)) |
      (lo_car & (next_path == dsmsel_pkg::dsmsel_use_low));
  wire next_out = enable ? (mixed ^ out_inv) : 1'b0;

  // Pin drive enables of the peripherals feeding the modulator
  dsmsel_pkg::dsmsel_pin_enable_type next_en;
  always_comb begin
    next_en = '1;
    if (src_disable) begin
      if (is_spi) next_en.spi_sdo[spi_idx[0]] = 1'b0;
      if (is_uart) next_en.uart_tx[uart_idx[1:0]] = 1'b0;
      if (is_cmp) next_en.cmp_out[cmp_idx[2:0]] = 1'b0;
    end
    if (hi_dis) begin
      if (hi_sel == dsmsel_pkg::car_refclk) next_en.refclk = 1'b0;
      if (hi_sel >= dsmsel_pkg::car_cmp_first && hi_sel <= dsmsel_pkg::car_cmp_last) begin
        next_en.cmp_out[hi_sel[2:0] - 3'h4] = 1'b0;
      end
    end
    if (lo_dis) begin
      if (lo_sel == dsmsel_pkg::car_refclk) next_en.refclk = 1'b0;
      if (lo_sel >= dsmsel_pkg::car_cmp_first && lo_sel <= dsmsel_pkg::car_cmp_last) begin
        next_en.cmp_out[lo_sel[2:0] - 3'h4] = 1'b0;
      end
    end
  end

  // Wishbone decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i;
  wire hit_ctrl = wb_adr_i == dsmsel_pkg::ctrl_offset;
  wire hit_src = wb_adr_i == dsmsel_pkg::src_offset;
  wire hit_car = wb_adr_i == dsmsel_pkg::car_offset;
  wire [15:0] ctrl_mask = 16'h8011;
  wire [15:0] car_mask = 16'hefef;
  wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] ctrl_w = (ctrl_reg & ~lane_mask) | (wb_dat_i[15:0] & lane_mask & ctrl_mask);
  wire [15:0] car_w = (car_reg & ~lane_mask) | (wb_dat_i[15:0] & lane_mask & car_mask);
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_reg} :
      hit_src ? {24'h000000, src_reg} :
      hit_car ? {16'h0000, car_reg} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= 16'h0000;
      src_disable <= 1'b0;
      car_reg[dsmsel_pkg::lo_disable_bit] <= 1'b0;
      path <= dsmsel_pkg::dsmsel_use_low;
      hi_prev <= 1'b0;
      lo_prev <= 1'b0;
      out_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      en_q <= '1;
    end else begin
      ack_q <= req;
      rdat_q <= (req && !wb_we_i) ? rd_mux : 32'h00000000;
      if (wr && hit_ctrl) ctrl_reg <= ctrl_w;
      if (wr && hit_src && wb_sel_i[0]) src_disable <= wb_dat_i[dsmsel_pkg::src_disable_bit];
      if (wr && hit_car) car_reg <= car_w;
      path <= next_path;
      hi_prev <= hi_car;
      lo_prev <= lo_car;
      out_q <= next_out;
      en_q <= next_en;
    end
  end

  // Fields left alone by reset
  always_ff @(posedge clk_i) begin
    if (!rst_i && wr && hit_src && wb_sel_i[0]) begin
      src_code <= wb_dat_i[dsmsel_pkg::sel_lsb +: 4];
    end
  end

  assign src_reg = {src_disable, 3'h0, src_code};
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign modulated_output_pin_o = out_q;
  assign pin_en_o = en_q;
endmodule

//--- hw/dsmsel_pkg.sv
// Package for the data signal modulator selection block
// Assumes a classic Wishbone slave with 32-bit data and byte addresses
package dsmsel_pkg;
  localparam int unsigned adr_width = 4;
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] src_offset = 4'h4;
  localparam logic [3:0] car_offset = 4'h8;
  // Control register fields
  localparam int unsigned ctl_enable_bit = 15;
  localparam int unsigned ctl_invert_bit = 4;
  localparam int unsigned ctl_manual_bit = 0;
  // Source register fields
  localparam int unsigned src_disable_bit = 7;
  localparam int unsigned sel_lsb = 0;
  localparam int unsigned sel_width = 4;
  // Carrier register fields
  localparam int unsigned hi_disable_bit = 15;
  localparam int unsigned hi_invert_bit = 14;
  localparam int unsigned hi_sync_bit = 13;
  localparam int unsigned hi_sel_lsb = 8;
  localparam int unsigned lo_disable_bit = 7;
  localparam int unsigned lo_invert_bit = 6;
  localparam int unsigned lo_sync_bit = 5;
  localparam int unsigned lo_sel_lsb = 0;
  // Source codes
  localparam logic [3:0] src_manual = 4'h0;
  localparam logic [3:0] src_pin = 4'h1;
  localparam logic [3:0] src_spi_first = 4'h2;
  localparam logic [3:0] src_uart_first = 4'h4;
  localparam logic [3:0] src_cmp_first = 4'h8;
  localparam logic [3:0] src_none = 4'hf;
  // Carrier codes
  localparam logic [3:0] car_ground = 4'h0;
  localparam logic [3:0] car_pin_one = 4'h1;
  localparam logic [3:0] car_pin_two = 4'h2;
  localparam logic [3:0] car_refclk = 4'h3;
  localparam logic [3:0] car_cmp_first = 4'h4;
  localparam logic [3:0] car_cmp_last = 4'ha;
  localparam int unsigned spi_count = 2;
  localparam int unsigned uart_count = 4;
  localparam int unsigned cmp_count = 7;
  localparam logic [1:0] sync_reset = 2'h0;

  typedef struct packed {
    logic [spi_count-1:0] spi_sdo;
    logic [uart_count-1:0] uart_tx;
    logic [cmp_count-1:0] cmp_out;
    logic mod_pin;
    logic car_pin_one;
    logic car_pin_two;
    logic refclk;
  } dsmsel_inputs_type;

  typedef struct packed {
    logic [spi_count-1:0] spi_sdo;
    logic [uart_count-1:0] uart_tx;
    logic [cmp_count-1:0] cmp_out;
    logic refclk;
  } dsmsel_pin_enable_type;

  typedef enum logic [0:0] {
    dsmsel_use_low = 1'b0,
    dsmsel_use_high = 1'b1
  } dsmsel_path_type;
endpackage

//--- verif/dsmsel_top_asserts.sv
// Checker for the modulator selection block bus and outputs
// Assumes aligned classic Wishbone requests held until ack
`timescale 1ns/1ps
module dsmsel_top_asserts (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [dsmsel_pkg::adr_width-1:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire dsmsel_pkg::dsmsel_pin_enable_type pin_en_o, // Pin enables
  input wire logic modulated_output_pin_o // Output
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] sh [3];
  wire rd = wb_ack_o && !wb_we_i;
  wire [1:0] ix = wb_adr_i[3:2];
  // Register shadow with the same reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh[0] <= 16'h0;
      sh[1][7] <= 1'b0;
      sh[2][7] <= 1'b0;
    end else if (wb_ack_o && wb_we_i && ix != 2'h3) begin
      if (wb_sel_i[0]) sh[ix][7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) sh[ix][15:8] <= wb_dat_i[15:8];
    end
  end
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("long ack");
  property p_ctl_rd; rd && ix == 2'h0 |-> wb_dat_o == {16'h0, sh[0] & 16'h8011}; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
  property p_src_rd; rd && ix == 2'h1 |-> wb_dat_o == {16'h0, sh[1] & 16'h008f}; endproperty
  a_src_rd: assert property (p_src_rd) else $error("source read");
  property p_car_rd; rd && ix == 2'h2 |-> wb_dat_o == {16'h0, sh[2] & 16'hefef}; endproperty
  a_car_rd: assert property (p_car_rd) else $error("carrier read");
  property p_off; (!sh[0][15] && !sh[0][4]) [*8] |-> !modulated_output_pin_o; endproperty
  a_off: assert property (p_off) else $error("output while off");
  property p_pins; (!sh[1][7] && !sh[2][15] && !sh[2][7]) [*3] |-> pin_en_o == '1; endproperty
  a_pins: assert property (p_pins) else $error("pin blocked");
  property p_uart; (sh[1][7] && sh[1][3:0] == 4'h4) [*3] |-> !pin_en_o.uart_tx[0]; endproperty
  a_uart: assert property (p_uart) else $error("pin not blocked");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_out: cover property (modulated_output_pin_o);
  c_block: cover property (pin_en_o != '1);
endmodule
bind dsmsel_top dsmsel_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_en_o(pin_en_o),
  .modulated_output_pin_o(modulated_output_pin_o));

//--- verif/dsmsel_periph_model.sv
// Peripheral outputs and carrier and modulation pins
// Assumes the bench names the line that carries the data
`timescale 1ns/1ps
module dsmsel_periph_model (
  input wire logic clk_i, // Clock
  input wire logic [4:0] pick_i, // Data line index
  input wire logic data_i, // Data value
  output dsmsel_pkg::dsmsel_inputs_type sig_o // Line levels
);
  // Picked line shows data, every other line its inverse
  always_ff @(posedge clk_i) begin
    sig_o <= data_i ? 17'h1 << pick_i : ~(17'h1 << pick_i);
  end
endmodule

//--- verif/tb.sv
// Bench for the modulator selection block
// Assumes the peripheral model drives every signal input
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h3;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, out;
  logic data = 1'b0;
  logic [4:0] pick = 5'h0;
  logic [15:0] c, s, k;
  logic [15:0] r [3];
  dsmsel_pkg::dsmsel_inputs_type sig;
  dsmsel_pkg::dsmsel_pin_enable_type pen;
  integer seed = 32'he7c6;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #10 clk_i = ~clk_i;
  dsmsel_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sig_i(sig), .pin_en_o(pen), .modulated_output_pin_o(out));
  dsmsel_periph_model u_model (.clk_i(clk_i), .pick_i(pick), .data_i(data), .sig_o(sig));
  // Line index of a source code, 31 for none
  function automatic logic [4:0] sbit(input logic [3:0] x);
    if (x == 4'h0 || x == 4'hf) return 5'h1f;
    if (x == 4'h1) return 5'h3;
    if (x < 4'h4) return {1'b0, x} + 5'hd;
    if (x < 4'h8) return {1'b0, x} + 5'h7;
    return {1'b0, x} - 5'h4;
  endfunction
  function automatic logic [4:0] cbit(input logic [3:0] x);
    if (x == 4'h0 || x > 4'ha) return 5'h1f;
    if (x < 4'h4) return 5'h3 - {1'b0, x};
    return {1'b0, x};
  endfunction
  function automatic logic [13:0] pblk(input logic [4:0] i);
    if (i == 5'h0) return 14'h1;
    if (i > 5'h3 && i < 5'h11) return 14'h1 << (i - 5'h3);
    return 14'h0;
  endfunction
  function automatic logic ln(input logic [4:0] i, input logic [4:0] p, input logic d);
    return i == 5'h1f ? 1'b0 : (i == p ? d : !d);
  endfunction
  function automatic logic eo(input logic [15:0] x, y, z, input logic [4:0] p, input logic d);
    logic m, h, l;
    m = y[3:0] == 4'h0 ? x[0] : ln(sbit(y[3:0]), p, d);
    h = ln(cbit(z[11:8]), p, d) ^ z[14];
    l = ln(cbit(z[3:0]), p, d) ^ z[6];
    return (x[15] & (m ? h : l)) ^ x[4];
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0);
    chk(q, {16'h0, e});
  endtask
  task automatic cfg(input logic [4:0] p);
    logic [13:0] b;
    wb(1'b1, 4'h0, c);
    wb(1'b1, 4'h4, s);
    wb(1'b1, 4'h8, k);
    b = (s[7] ? pblk(sbit(s[3:0])) : 14'h0) | (k[15] ? pblk(cbit(k[11:8])) : 14'h0);
    b = b | (k[7] ? pblk(cbit(k[3:0])) : 14'h0);
    pick <= p;
    for (int i = 0; i < 2; i++) begin
      data <= ~data;
      repeat (8) @(posedge clk_i);
      chk({31'h0, out}, {31'h0, eo(c, s, k, p, data)});
      chk({18'h0, pen}, {18'h0, ~b});
    end
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      r[i] = 16'($random(seed));
      wb(1'b1, 4'(4 * i), r[i]);
    end
    wb(1'b1, 4'hc, 16'hffff);
    rd(4'h0, r[0] & 16'h8011);
    rd(4'h4, r[1] & 16'h008f);
    rd(4'h8, r[2] & 16'hefef);
    rd(4'hc, 16'h0);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 16'h0);
    rd(4'h4, r[1] & 16'h000f);
    rd(4'h8, r[2] & 16'hef6f);
    for (int i = 0; i < 16; i++) begin
      c = 16'h8000 | 16'($random(seed) & 1);
      s = 16'(i) | 16'($random(seed) & 16'h0080);
      k = 16'h4000;
      cfg(sbit(4'(i)));
      k = (16'(i) << 8) | (i < 11 ? 16'($random(seed) & 16'hc000) : 16'h8000);
      c = 16'h8001;
      cfg(cbit(4'(i)));
      k = 16'(i) | (i < 11 ? 16'($random(seed) & 16'h00c0) : 16'h0080);
      c = 16'h8000;
      cfg(cbit(4'(i)));
    end
    for (int n = 0; n < 60; n++) begin
      c = 16'($random(seed) & 16'h8011);
      c[4] = c[4] & c[15];
      s = 16'($random(seed));
      k = 16'($random(seed)) & 16'hdfdf;
      k[14] = k[14] & (k[11:8] < 4'hb);
      k[6] = k[6] & (k[3:0] < 4'hb);
      cfg(($random(seed) & 1) ? sbit(s[3:0]) : cbit(k[11:8]));
    end
    // Switch away from a carrier held while that carrier stays high
    pick <= 5'h2;
    for (int i = 0; i < 2; i++) begin
      data <= 1'b0;
      wb(1'b1, 4'h0, i ? 16'h8000 : 16'h8001);
      wb(1'b1, 4'h8, i ? 16'h0221 : 16'h2102);
      repeat (8) @(posedge clk_i);
      data <= 1'b1;
      repeat (8) @(posedge clk_i);
      wb(1'b1, 4'h0, i ? 16'h8001 : 16'h8000);
      repeat (8) @(posedge clk_i);
      chk({31'h0, out}, 32'h1);
    end
    end_of_test();
  end
endmodule
